// ==== design/cbt_bit_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbt_bit_timer
	import cbt_pkg::*;
(
	// Clock and reset
	input  wire logic         clock_in,
	input  wire logic         rst_in,
	// Segment lengths
	cbt_seg_if.dst            seg,
	// Timing outputs
	output logic              tq_tick_out,
	output logic              sample_point_out,
	output cbt_pkg::cbt_seg_e segment_out
);
	import cbt_pkg::*;

	logic [5:0] pre_cnt;
	logic [3:0] tq_cnt;

	// Quantum is divider+1 module clocks wide, one tick per quantum
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			pre_cnt     <= 6'h00;
			tq_tick_out <= 1'b0;
		end else if (pre_cnt >= seg.divider) begin
			pre_cnt     <= 6'h00;
			tq_tick_out <= 1'b1;
		end else begin
			pre_cnt     <= pre_cnt + 6'h01;
			tq_tick_out <= 1'b0;
		end
	end

	// Segment walk: sync, propagation, phase one, phase two
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			segment_out      <= CBT_SYNC;
			tq_cnt           <= 4'h0;
			sample_point_out <= 1'b0;
		end else begin
			sample_point_out <= 1'b0;
			if (tq_tick_out) begin
				case (segment_out)
					CBT_SYNC: begin
						segment_out <= CBT_PROP;
						tq_cnt      <= 4'h1;
					end
					CBT_PROP: begin
						if (tq_cnt >= seg.prop_tq) begin
							segment_out <= CBT_PH1;
							tq_cnt      <= 4'h1;
						end else begin
							tq_cnt <= tq_cnt + 4'h1;
						end
					end
					CBT_PH1: begin
						if (tq_cnt >= seg.ph1_tq) begin
							segment_out      <= CBT_PH2;
							sample_point_out <= 1'b1; // End of phase one is the sample point
							tq_cnt           <= 4'h1;
						end else begin
							tq_cnt <= tq_cnt + 4'h1;
						end
					end
					CBT_PH2: begin
						if (tq_cnt >= seg.ph2_tq) begin
							segment_out <= CBT_SYNC;
							tq_cnt      <= 4'h0;
						end else begin
							tq_cnt <= tq_cnt + 4'h1;
						end
					end
					default: begin
						segment_out <= CBT_SYNC;
						tq_cnt      <= 4'h0;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ==== design/cbt_pkg.sv ====
// Contract
// - Wake filter enable routes bus line through wake-up filter, else bypassed.
// - Phase two field gives segment two of code plus one quanta.
// - Phase one field gives segment one of code plus one quanta.
// - Free select uses programmed phase two, else max of phase one and IPT.
// - Majority vote select takes three samples at sample point, else one. Code: samples at the last three quantum ticks, ending at the sample point.
// - Phase two not longer than phase one; hardware derives it when not free. Code: free phase two is not clamped, derived is max of phase one and IPT.
// - Timing register writable only in configuration mode, code 100.
// - Unimplemented bits read zero and ignore writes.
package cbt_pkg;
	localparam logic [3:0]  CBT_ADDR_TIMING = 4'h0;
	localparam logic [3:0]  CBT_ADDR_MODE   = 4'h4;
	localparam logic [3:0]  CBT_ADDR_STATUS = 4'h8;
	localparam logic [31:0] CBT_TIMING_MASK = 32'h0047FFFF;
	localparam logic [31:0] CBT_TIMING_RST  = 32'h00000000;
	localparam logic [2:0]  CBT_MODE_CONFIG = 3'h4;
	localparam logic [2:0]  CBT_MODE_RST    = 3'h4;
	localparam int          CBT_WAKE_BIT    = 22;
	localparam int          CBT_P2_LSB      = 16;
	localparam int          CBT_FREE_BIT    = 15;
	localparam int          CBT_VOTE_BIT    = 14;
	localparam int          CBT_P1_LSB      = 11;
	localparam int          CBT_PROP_LSB    = 8;
	localparam int          CBT_JUMP_LSB    = 6;
	localparam logic [3:0]  CBT_IPT_TQ      = 4'h2;
	localparam int          CBT_CLK_MHZ     = 40;
	localparam int          CBT_WAKE_NS     = 700;
	localparam logic [5:0]  CBT_WAKE_CYC    = 6'((CBT_WAKE_NS * CBT_CLK_MHZ + 999) / 1000);
	typedef enum logic [1:0] {
		CBT_SYNC  = 2'b00,
		CBT_PROP  = 2'b01,
		CBT_PH1   = 2'b11,
		CBT_PH2   = 2'b10
	} cbt_seg_e;
endpackage

// ==== design/cbt_seg_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Quantum divider and segment lengths in quanta handed to the bit timer
interface cbt_seg_if;
	logic [5:0] divider;
	logic [3:0] prop_tq;
	logic [3:0] ph1_tq;
	logic [3:0] ph2_tq;
	modport src (output divider, prop_tq, ph1_tq, ph2_tq);
	modport dst (input divider, prop_tq, ph1_tq, ph2_tq);
endinterface
`default_nettype wire

// ==== design/cbt_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbt_top
	import cbt_pkg::*;
(
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        rst_in,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	// CAN bus line
	input  wire logic        can_rx_in,
	// Timing and receive outputs
	output logic             tq_tick_out,
	output logic             sample_point_out,
	output logic             rx_bit_out,
	output logic             rx_bit_valid_out,
	output logic             wake_out
);
	import cbt_pkg::*;

	// Register state and bus handshake
	logic [31:0] timing;
	logic [2:0]  operating_mode_field;
	logic        ack;
	// Bus line path and wake-up filter
	logic [2:0]  rx_sync;
	logic        rx_level;
	logic [2:0]  vote;
	logic [5:0]  wake_cnt;
	// Segment lengths and bit timer outputs
	logic [3:0]  ph1_len;
	logic [3:0]  ph2_len;
	logic        tick;
	logic        spt;
	cbt_seg_e    segment;
	cbt_seg_if   seg ();

	// A field code n stands for n+1 quanta, so no code gives an empty segment
	function automatic logic [3:0] tq_len(input logic [2:0] code);
		return {1'b0, code} + 4'h1;
	endfunction

	// Byte lanes that the master leaves disabled keep their old value; the
	// mask is applied afterwards so unused bits can never be set this way
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		return r;
	endfunction

	// Two out of three; one disturbed quantum cannot flip the received bit
	function automatic logic majority(input logic [2:0] s);
		return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	// Waitrequest comes from a flop: high while idle and in the first cycle
	// of an access, low in the second. Every access costs two cycles, which
	// buys a registered read path and a glitch-free handshake.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			avs_waitrequest_out <= 1'b1;
		end else begin
			avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & avs_waitrequest_out);
		end
	end

	// The access completes at the edge that ends this cycle
	assign ack = (avs_read_in | avs_write_in) & ~avs_waitrequest_out;

	// Timing register, writable only in configuration mode. A write in any
	// other mode still completes on the bus but leaves the register alone.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			timing <= CBT_TIMING_RST;
		end else if (avs_write_in && ack && avs_address_in == CBT_ADDR_TIMING
			&& operating_mode_field == CBT_MODE_CONFIG) begin
			timing <= merge(timing, avs_writedata_in, avs_byteenable_in)
				& CBT_TIMING_MASK;
		end
	end

	// Operating mode field of the control register; it sits in the low lane
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			operating_mode_field <= CBT_MODE_RST;
		end else if (avs_write_in && ack && avs_address_in == CBT_ADDR_MODE
			&& avs_byteenable_in[0]) begin
			operating_mode_field <= avs_writedata_in[2:0];
		end
	end

	// Read mux; unmapped addresses read zero. Loaded in the wait cycle so the
	// word already stands at the accepting edge.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			avs_readdata_out <= 32'h00000000;
		end else if (avs_read_in && !ack) begin
			case (avs_address_in)
				CBT_ADDR_TIMING: avs_readdata_out <= timing & CBT_TIMING_MASK;
				CBT_ADDR_MODE:   avs_readdata_out <= {29'h0, operating_mode_field};
				CBT_ADDR_STATUS: avs_readdata_out <= {22'h0, ph2_len, ph1_len, segment};
				default:         avs_readdata_out <= 32'h00000000;
			endcase
		end
	end

	// Segment lengths; phase two derived when not freely programmable. The
	// derived value follows phase one at once, so no stale copy can linger.
	always_comb begin
		ph1_len = tq_len(timing[CBT_P1_LSB +: 3]);
		if (timing[CBT_FREE_BIT])
			ph2_len = tq_len(timing[CBT_P2_LSB +: 3]);
		else
			ph2_len = (ph1_len > CBT_IPT_TQ) ? ph1_len : CBT_IPT_TQ;
	end
	// Divider in module clocks and lengths in quanta handed to the bit timer
	assign seg.divider = timing[5:0];
	assign seg.prop_tq = tq_len(timing[CBT_PROP_LSB +: 3]);
	assign seg.ph1_tq  = ph1_len;
	assign seg.ph2_tq  = ph2_len;

	// Bit timer works from the live lengths; a change in mid-bit takes effect
	// at the next quantum tick, even in the running segment, which is harmless in configuration mode
	cbt_bit_timer u_timer (
		.clock_in         (clock_in),
		.rst_in           (rst_in),
		.seg              (seg),
		.tq_tick_out      (tick),
		.sample_point_out (spt),
		.segment_out      (segment)
	);

	// Bus line synchroniser; a change counts once stages two and three agree.
	// Four cycles of latency buy immunity to metastability, and a one-cycle
	// spike on the line never reaches the sampling logic.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rx_sync  <= 3'b111;
			rx_level <= 1'b1;
		end else begin
			rx_sync <= {rx_sync[1:0], can_rx_in};
			if (rx_sync[1] == rx_sync[2])
				rx_level <= rx_sync[2];
		end
	end

	// Sample history: last three quanta for majority voting. The samples are
	// one quantum apart, so they span the end of phase one, not one instant.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			vote <= 3'b111;
		end else if (tick) begin
			vote <= {vote[1:0], rx_level};
		end
	end

	// Received bit at the sample point; valid pulses for one cycle per bit
	// and the bit itself holds until the next sample point
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rx_bit_out       <= 1'b1;
			rx_bit_valid_out <= 1'b0;
		end else begin
			rx_bit_valid_out <= spt;
			if (spt) begin
				if (timing[CBT_VOTE_BIT]) begin
					rx_bit_out <= majority(vote);
				end else begin
					rx_bit_out <= vote[0];
				end
			end
		end
	end

	// Wake-up: filter needs a dominant pulse of the minimum width
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			wake_cnt <= 6'h00;
			wake_out <= 1'b0;
		end else begin
			// The count stops at the filter length so a long dominant level cannot wrap it
			if (rx_level) begin
				wake_cnt <= 6'h00;
			end else if (wake_cnt != CBT_WAKE_CYC) begin
				wake_cnt <= wake_cnt + 6'h01;
			end
			// With the filter off any dominant level wakes at once
			if (timing[CBT_WAKE_BIT]) begin
				wake_out <= !rx_level && wake_cnt == CBT_WAKE_CYC;
			end else begin
				wake_out <= !rx_level;
			end
		end
	end

	// Registered copies for the top outputs; one cycle behind the timer,
	// which keeps every top output straight from a flop
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			tq_tick_out      <= 1'b0;
			sample_point_out <= 1'b0;
		end else begin
			tq_tick_out      <= tick;
			sample_point_out <= spt;
		end
	end
endmodule
`default_nettype wire

// ==== verification/cbt_can_node.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbt_can_node (
	// Clock and pulse request
	input wire logic       clock_in,
	input wire logic       start_in,
	input wire logic [7:0] len_in,
	// Bus line, recessive high
	output logic           rx_out
);
	logic [7:0] cnt = 8'h00;
	// Dominant for len_in cycles, then back to the pull-up level
	always @(posedge clock_in) begin
		if (start_in)
			cnt <= len_in;
		else if (cnt != 8'h00)
			cnt <= cnt - 8'h01;
	end
	assign rx_out = (cnt == 8'h00);
endmodule
`default_nettype wire

// ==== verification/cbt_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbt_monitor
	import cbt_pkg::*;
(
	// Clock, reset and bus
	input wire logic        clock_in,
	input wire logic        rst_in,
	input wire logic [3:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        avs_waitrequest_out,
	// Line and timing
	input wire logic        can_rx_in,
	input wire logic        sample_point_out,
	input wire logic        rx_bit_valid_out,
	input wire logic        wake_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// Accepted read; unmapped places must read as zero
	logic rd_ok;
	logic unmapped;
	assign rd_ok = avs_read_in & ~avs_waitrequest_out;
	assign unmapped = (avs_address_in != CBT_ADDR_TIMING) && (avs_address_in != CBT_ADDR_MODE)
		&& (avs_address_in != CBT_ADDR_STATUS);
	a_wait_first: assert property (
		(avs_read_in | avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("wait held too long");
	a_wait_idle: assert property (
		!(avs_read_in | avs_write_in) |=> avs_waitrequest_out) else $error("no wait after idle");
	a_timing_zero: assert property (
		rd_ok && avs_address_in == CBT_ADDR_TIMING |-> (avs_readdata_out & ~CBT_TIMING_MASK) == 32'h0)
		else $error("unused timing bits set");
	a_unmapped_zero: assert property (
		rd_ok && unmapped |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
	a_read_hold: assert property (
		!avs_read_in |=> $stable(avs_readdata_out)) else $error("read data moved");
	a_sample_gap: assert property (
		sample_point_out |=> !sample_point_out [*3]) else $error("sample points too close");
	a_valid_pulse: assert property (
		rx_bit_valid_out |=> !rx_bit_valid_out) else $error("valid not a pulse");
	a_wake_quiet: assert property (
		can_rx_in [*8] |=> !$rose(wake_out)) else $error("wake on quiet line");
endmodule
bind cbt_top cbt_monitor i_cbt_monitor (
	.clock_in            (clock_in),
	.rst_in              (rst_in),
	.avs_address_in      (avs_address_in),
	.avs_read_in         (avs_read_in),
	.avs_write_in        (avs_write_in),
	.avs_readdata_out    (avs_readdata_out),
	.avs_waitrequest_out (avs_waitrequest_out),
	.can_rx_in           (can_rx_in),
	.sample_point_out    (sample_point_out),
	.rx_bit_valid_out    (rx_bit_valid_out),
	.wake_out            (wake_out)
);
`default_nettype wire

// ==== verification/tb_can_bit_timing_config.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_can_bit_timing_config;
	import cbt_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic        st = 1'b0;
	logic        seen = 1'b0;
	logic        rx, wq, rb, rv, wk, tq;
	int          n;
	logic [3:0]  adr = 4'h0;
	logic [3:0]  be = 4'h0;
	logic [3:0]  b;
	logic [7:0]  len = 8'h00;
	logic [31:0] wd = 32'h0, rdat, q, w, cur;
	int          errors = 0;
	int          num_checks = 0;
	// 40 MHz clock
	always #12.5 clk = ~clk;
	// Any wake level during a pulse counts
	always @(posedge clk) if (wk === 1'b1) seen = 1'b1;
	cbt_top i_cbt_top (.clock_in(clk), .rst_in(rst), .avs_address_in(adr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdat),
		.avs_waitrequest_out(wq), .can_rx_in(rx), .tq_tick_out(tq), .sample_point_out(),
		.rx_bit_out(rb), .rx_bit_valid_out(rv), .wake_out(wk));
	cbt_can_node i_cbt_can_node (.clock_in(clk), .start_in(st), .len_in(len), .rx_out(rx));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// One bus cycle; waitrequest and read data are taken at the accepting edge
	task automatic acc(input logic w_, input logic [3:0] a, input logic [31:0] d, input logic [3:0] e);
		int k;
		k = 0;
		adr <= a;
		wd <= d;
		be <= e;
		rd <= !w_;
		wr <= w_;
		do begin
			@(posedge clk);
			k++;
		end while (wq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
		chk(k, 2);
	endtask
	// Expected segment lengths in quanta: {phase two, phase one}
	function automatic logic [7:0] lens(input logic [31:0] v);
		logic [3:0] p1;
		logic [3:0] p2;
		p1 = {1'b0, v[13:11]} + 4'h1;
		p2 = v[15] ? {1'b0, v[18:16]} + 4'h1 : (p1 > CBT_IPT_TQ ? p1 : CBT_IPT_TQ);
		return {p2, p1};
	endfunction
	// Dominant pulse from the far node, then look for a wake level
	task automatic pulse(input logic [7:0] l, input logic e);
		seen = 1'b0;
		len <= l;
		st <= 1'b1;
		@(posedge clk);
		st <= 1'b0;
		repeat (60) @(posedge clk);
		chk(seen, e);
	endtask
	initial begin
		void'($urandom(33672));
		cur = 32'h0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		acc(0, CBT_ADDR_TIMING, 0, 0);
		chk(q, CBT_TIMING_RST);
		acc(0, CBT_ADDR_MODE, 0, 0);
		chk(q[2:0], CBT_MODE_RST);
		// Phase one at least 5, phase two at most 4, divider at least 2, jump width 0; the first write, 32'hFFF8_0702, has phase one 1
		for (int i = 0; i < 12; i++) begin
			w = ($urandom & 32'hFFFB_FF00) | 32'h2000 | (32'($urandom % 4) + 32'h2);
			b = 4'($urandom);
			if (i == 0) w = 32'hFFF8_0702;
			if (i == 0) b = 4'hF;
			acc(1, CBT_ADDR_TIMING, w, b);
			for (int k = 0; k < 4; k++) if (b[k]) cur[8*k+:8] = w[8*k+:8];
			cur &= CBT_TIMING_MASK;
			acc(0, CBT_ADDR_TIMING, 0, 0);
			chk(q, cur);
			acc(0, CBT_ADDR_STATUS, 0, 0);
			chk(q[9:2], lens(cur));
		end
		acc(1, 4'hC, 32'hFFFF_FFFF, 4'hF);
		acc(0, 4'hC, 0, 0);
		chk(q, 0);
		$display("register test done");
		acc(1, CBT_ADDR_MODE, 0, 4'hF);
		acc(1, CBT_ADDR_TIMING, ~cur, 4'hF);
		acc(0, CBT_ADDR_TIMING, 0, 0);
		chk(q, cur);
		for (int k = 0; k < 3000 && rv !== 1'b1; k++) @(posedge clk);
		chk({rv, rb}, 2'b11);
		// Quantum spacing: one tick every divider+1 module clocks
		for (int k = 0; k < 3000 && tq !== 1'b1; k++) @(posedge clk);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (tq !== 1'b1 && n < 100);
		chk(n, 32'(cur[5:0]) + 32'h1);
		acc(1, CBT_ADDR_MODE, 32'h4, 4'hF);
		$display("mode test done");
		for (int f = 0; f < 2; f++) begin
			cur[22] = f[0];
			acc(1, CBT_ADDR_TIMING, cur, 4'hF);
			pulse(8'd10, !f[0]);
			pulse(8'd40, 1'b1);
		end
		$display("wake test done");
		report_and_stop();
	end
	// Watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
